// ==== verilog/periph_pkg.sv ====
// Purpose: constants for the peripheral control unit
// Assumes: 100 MHz ref_clk_i, byte-wide register port
// Notes:   offsets are byte addresses of the register port
// Contract
// - cadence timer counts 0..127 steps of 100 ms, cyclic when count field is 7
// - ring timer period 1..63 ms drives output pin, cyclic when bit set
// - every edge on either external interrupt pin sets its flag
// - unmasked set external flag raises the interrupt request
// - external flags sit in main status, masks in main mask (set bit blocks the request)
// - pin levels readable in multiframe receive status bits
// - bus-select bit chooses simple pins or 8-bit bus
// - simple mode exposes pins through address and data registers
// - pin driven from stored bit only while its enable is set
// - simple mode reads return actual pin level
// - simple mode offers at most eleven pins
// - bus mode multiplexes address and data on one 8-bit bus
// - latch strobe during address, active-low read and write strobes
// - bus mode addresses up to 256 byte locations
// - cadence timer starts on command, stops on timer write or on expiry unless cyclic
package periph_pkg;
  localparam logic [7:0] OFS_CAD_TIMER  = 8'h10;
  localparam logic [7:0] OFS_MAIN_STAT  = 8'h14;
  localparam logic [7:0] OFS_MAIN_MASK  = 8'h18;
  localparam logic [7:0] OFS_DEXT_STAT  = 8'h1C;
  localparam logic [7:0] OFS_DEXT_MASK  = 8'h20;
  localparam logic [7:0] OFS_RING_TIMER = 8'h4C;
  localparam logic [7:0] OFS_MF_STATUS  = 8'h60;
  localparam logic [7:0] OFS_PERIPH_CTL = 8'h68;
  localparam logic [7:0] OFS_EXT_ADDR   = 8'hF4;
  localparam logic [7:0] OFS_EXT_DATA   = 8'hF8;
  localparam logic [7:0] OFS_CMD        = 8'h08;
  // field positions
  localparam int BIT_START_CAD   = 4;
  localparam int BIT_XFLAG0      = 3;
  localparam int BIT_XFLAG1      = 4;
  localparam int BIT_DEXI        = 2;
  localparam int BIT_CAD_EXP     = 1;
  localparam int BIT_RING_IRQ    = 4;
  localparam int BIT_LVL0        = 6;
  localparam int BIT_LVL1        = 7;
  localparam int BIT_BUS_SEL     = 1;
  localparam int BIT_RING_CYC    = 7;
  localparam int BIT_RING_IDLE   = 6;
  localparam int BIT_CAD_MODE    = 7;
  localparam logic [6:0] CAD_CYCLIC_CNT = 7'h07;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] DEXT_MASK_RST  = 8'hFF;
  localparam logic [7:0] MAIN_MASK_RST  = 8'hFF;
  // timing
  localparam int CLK_MHZ        = 100;
  localparam int CAD_STEP_MS    = 100;
  localparam int RING_STEP_MS   = 1;
  localparam int MS_CYCLES      = CLK_MHZ * 1000;
  localparam int CAD_STEP_CYC   = CAD_STEP_MS * MS_CYCLES;
  localparam int RING_STEP_CYC  = RING_STEP_MS * MS_CYCLES;
  localparam int NUM_PINS       = 11;
  localparam int BUS_PHASE_CYC  = 4;
endpackage : periph_pkg

// ==== verilog/edge_sync.sv ====
// Purpose: two-flop synchroniser with edge detect
// Assumes: async input pin
// Notes:   first flop read only by second
module edge_sync (
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      edge_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign edge_o  = sync_q ^ prev_q;
endmodule : edge_sync

// ==== verilog/peripheral_control_unit.sv ====
// Purpose: timers, external interrupt inputs and peripheral port
// Assumes: byte register port, one access per strobe
// Notes:   data reads in bus mode return the last sampled byte
module peripheral_control_unit #(
  parameter int CAD_STEP_CYC  = periph_pkg::CAD_STEP_CYC,
  parameter int RING_STEP_CYC = periph_pkg::RING_STEP_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_busy_o,
  output logic             irq_o,
  input  wire logic        ext_irq_pin0_i,
  input  wire logic        ext_irq_pin1_i,
  output logic             ring_timer_out_pin_o,
  input  wire logic [10:0] port_pin_i,
  output logic      [10:0] port_pin_o,
  output logic      [10:0] port_pin_oe_o,
  output logic             ext_latch_strobe_o,
  output logic             ext_read_strobe_n_o,
  output logic             ext_write_strobe_n_o
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_GAP, BUS_DATA, BUS_DONE} bus_state_t;
  bus_state_t state_q;
  logic [7:0] cad_ctl_q, ring_ctl_q, main_stat_q, main_mask_q, dext_stat_q, dext_mask_q;
  logic [7:0] peripheral_ctrl_q, ext_address_reg_q, ext_data_port_q, rd_byte_q;
  logic       bus_wr_q;
  logic [1:0] ph_cnt_q;
  logic [7:0] cad_cnt_q;
  logic       cad_run_q;
  logic [31:0] cad_div_q, ring_div_q;
  logic [5:0] ring_cnt_q;
  logic       ring_run_q, ring_out_q;
  logic       lvl0, lvl1, edg0, edg1;

  wire bus_mode  = peripheral_ctrl_q[periph_pkg::BIT_BUS_SEL];
  wire hit_cad   = reg_addr_i == periph_pkg::OFS_CAD_TIMER;
  wire hit_mstat = reg_addr_i == periph_pkg::OFS_MAIN_STAT;
  wire hit_mmask = reg_addr_i == periph_pkg::OFS_MAIN_MASK;
  wire hit_dstat = reg_addr_i == periph_pkg::OFS_DEXT_STAT;
  wire hit_dmask = reg_addr_i == periph_pkg::OFS_DEXT_MASK;
  wire hit_ring  = reg_addr_i == periph_pkg::OFS_RING_TIMER;
  wire hit_mf    = reg_addr_i == periph_pkg::OFS_MF_STATUS;
  wire hit_peripheral_ctrl  = reg_addr_i == periph_pkg::OFS_PERIPH_CTL;
  wire hit_ext_address_reg = reg_addr_i == periph_pkg::OFS_EXT_ADDR;
  wire hit_ext_data_port = reg_addr_i == periph_pkg::OFS_EXT_DATA;
  wire hit_cmd   = reg_addr_i == periph_pkg::OFS_CMD;
  wire bus_idle  = state_q == BUS_IDLE;
  wire acc_ok    = !reg_busy_o;
  wire wr_en     = reg_wr_i && acc_ok;
  wire rd_en     = reg_rd_i && acc_ok;
  wire bus_start = bus_mode && hit_ext_data_port && (wr_en || rd_en);

  // ----------------------------------------
  // external interrupt inputs
  // ----------------------------------------
  edge_sync u_sync0 (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pin_i     (ext_irq_pin0_i),
    .level_o   (lvl0),
    .edge_o    (edg0)
  );
  edge_sync u_sync1 (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pin_i     (ext_irq_pin1_i),
    .level_o   (lvl1),
    .edge_o    (edg1)
  );

  // ----------------------------------------
  // timers
  // ----------------------------------------
  wire cad_tick   = cad_run_q && (cad_div_q == 32'(CAD_STEP_CYC - 1));
  wire cad_cyclic = cad_ctl_q[6:0] == periph_pkg::CAD_CYCLIC_CNT;
  wire cad_expire = cad_tick && (cad_cnt_q <= 8'd1);
  wire ring_tick  = ring_run_q && (ring_div_q == 32'(RING_STEP_CYC - 1));
  wire ring_exp   = ring_tick && (ring_cnt_q <= 6'd1);
  wire ring_cyc   = ring_ctl_q[periph_pkg::BIT_RING_CYC];
  wire cad_start  = wr_en && hit_cmd && reg_wdata_i[periph_pkg::BIT_START_CAD];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cad_run_q <= 1'b0;
      cad_cnt_q <= 8'h00;
      cad_div_q <= 32'h0;
    end else if (wr_en && hit_cad) begin
      cad_run_q <= 1'b0;
      cad_div_q <= 32'h0;
    end else if (cad_start) begin
      cad_run_q <= 1'b1;
      cad_cnt_q <= {1'b0, cad_ctl_q[6:0]};
      cad_div_q <= 32'h0;
    end else if (cad_run_q) begin
      cad_div_q <= cad_tick ? 32'h0 : cad_div_q + 32'h1;
      if (cad_expire) begin
        cad_run_q <= cad_cyclic;
        cad_cnt_q <= {1'b0, cad_ctl_q[6:0]};
      end else if (cad_tick) begin
        cad_cnt_q <= cad_cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ring_run_q <= 1'b0;
      ring_cnt_q <= 6'h00;
      ring_div_q <= 32'h0;
      ring_out_q <= 1'b0;
    end else if (wr_en && hit_ring) begin
      ring_run_q <= reg_wdata_i[5:0] != 6'h00;
      ring_cnt_q <= reg_wdata_i[5:0];
      ring_div_q <= 32'h0;
      ring_out_q <= reg_wdata_i[periph_pkg::BIT_RING_IDLE];
    end else if (ring_run_q) begin
      ring_div_q <= ring_tick ? 32'h0 : ring_div_q + 32'h1;
      if (ring_exp) begin
        ring_run_q <= ring_cyc;
        ring_cnt_q <= ring_ctl_q[5:0];
        ring_out_q <= ~ring_out_q;
      end else if (ring_tick) begin
        ring_cnt_q <= ring_cnt_q - 6'h01;
      end
    end
  end
  assign ring_timer_out_pin_o = ring_out_q;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  wire [7:0] mstat_set = {3'b000, edg1, edg0, 3'b000} |
                         ({5'h00, |(dext_stat_q & ~dext_mask_q), 2'b00});
  wire [7:0] dstat_set = {3'b000, ring_exp, 2'b00, cad_expire, 1'b0};
  wire       clr_mstat = rd_en && hit_mstat;
  wire       clr_dstat = rd_en && hit_dstat;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cad_ctl_q   <= periph_pkg::RESET_BYTE;
      ring_ctl_q  <= periph_pkg::RESET_BYTE;
      main_mask_q <= periph_pkg::MAIN_MASK_RST;
      dext_mask_q <= periph_pkg::DEXT_MASK_RST;
      peripheral_ctrl_q      <= periph_pkg::RESET_BYTE;
      ext_address_reg_q     <= periph_pkg::RESET_BYTE;
      ext_data_port_q     <= periph_pkg::RESET_BYTE;
    end else if (wr_en) begin
      if (hit_cad)   cad_ctl_q   <= reg_wdata_i;
      if (hit_ring)  ring_ctl_q  <= reg_wdata_i;
      if (hit_mmask) main_mask_q <= reg_wdata_i;
      if (hit_dmask) dext_mask_q <= reg_wdata_i;
      if (hit_peripheral_ctrl)  peripheral_ctrl_q      <= reg_wdata_i;
      if (hit_ext_address_reg) ext_address_reg_q     <= reg_wdata_i;
      if (hit_ext_data_port) ext_data_port_q     <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      main_stat_q <= periph_pkg::RESET_BYTE;
      dext_stat_q <= periph_pkg::RESET_BYTE;
    end else begin
      main_stat_q <= (clr_mstat ? 8'h00 : main_stat_q) | mstat_set;
      dext_stat_q <= (clr_dstat ? 8'h00 : dext_stat_q) | dstat_set;
    end
  end

  assign irq_o = |(main_stat_q & ~main_mask_q);

  // ----------------------------------------
  // peripheral port
  // ----------------------------------------
  // drive only when enabled
  wire [10:0] simple_oe = {peripheral_ctrl_q[4:2], peripheral_ctrl_q[7:5], peripheral_ctrl_q[7:5], peripheral_ctrl_q[7:6]};
  wire [10:0] simple_do = {ext_data_port_q[2:0], ext_address_reg_q};
  wire        bus_drive = (state_q == BUS_ADDR) || (state_q == BUS_GAP) || ((state_q == BUS_DATA) && bus_wr_q);
  wire [7:0]  bus_byte  = (state_q == BUS_DATA) ? ext_data_port_q : ext_address_reg_q;
  assign port_pin_o    = bus_mode ? {3'b000, bus_byte} : simple_do;
  assign port_pin_oe_o = bus_mode ? {3'b000, {8{bus_drive}}} : simple_oe;
  assign ext_latch_strobe_o   = state_q == BUS_ADDR;
  assign ext_read_strobe_n_o  = !((state_q == BUS_DATA) && !bus_wr_q);
  assign ext_write_strobe_n_o = !((state_q == BUS_DATA) && bus_wr_q);
  assign reg_busy_o           = !bus_idle;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q   <= BUS_IDLE;
      bus_wr_q  <= 1'b0;
      ph_cnt_q  <= 2'd0;
      rd_byte_q <= 8'h00;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (bus_start) begin
            state_q  <= BUS_ADDR;
            bus_wr_q <= wr_en;
            ph_cnt_q <= 2'd0;
          end
        end
        BUS_ADDR: state_q <= BUS_GAP;
        BUS_GAP:  state_q <= BUS_DATA;
        BUS_DATA: begin
          ph_cnt_q <= ph_cnt_q + 2'd1;
          if (ph_cnt_q == 2'(periph_pkg::BUS_PHASE_CYC - 1)) begin
            if (!bus_wr_q) rd_byte_q <= port_pin_i[7:0];
            state_q <= BUS_DONE;
          end
        end
        BUS_DONE: state_q <= BUS_IDLE;
        default:  state_q <= BUS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // level bits
  wire [7:0] mf_byte = {lvl1, lvl0, 6'h00};
  wire [7:0] ext_address_reg_rd = bus_mode ? ext_address_reg_q : port_pin_i[7:0];
  wire [7:0] ext_data_port_rd = bus_mode ? rd_byte_q : {5'h00, port_pin_i[10:8]};
  wire [7:0] rd_mux =
    hit_cad   ? cad_ctl_q   :
    hit_mstat ? main_stat_q :
    hit_mmask ? main_mask_q :
    hit_dstat ? dext_stat_q :
    hit_dmask ? dext_mask_q :
    hit_ring  ? ring_ctl_q  :
    hit_mf    ? mf_byte     :
    hit_peripheral_ctrl  ? peripheral_ctrl_q      :
    hit_ext_address_reg ? ext_address_reg_rd    :
    hit_ext_data_port ? ext_data_port_rd    : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) reg_rdata_o <= 8'h00;
    else if (rd_en) reg_rdata_o <= rd_mux;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_EDGE_FLAG: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    edg0 |=> main_stat_q[periph_pkg::BIT_XFLAG0]) else $error("edge flag missing");
  AST_IRQ_OUT: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (main_stat_q[periph_pkg::BIT_XFLAG1] && !main_mask_q[periph_pkg::BIT_XFLAG1]) |-> irq_o)
    else $error("irq not raised");
  AST_LEVEL_READ: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rd_en && hit_mf) |=> reg_rdata_o[periph_pkg::BIT_LVL0] == $past(lvl0)) else $error("level bit wrong");
  AST_PIN_OE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !bus_mode |-> port_pin_oe_o == simple_oe) else $error("pin enable wrong");
  AST_LATCH_SEQ: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(ext_latch_strobe_o) |=> !ext_latch_strobe_o ##1 (!ext_read_strobe_n_o || !ext_write_strobe_n_o))
    else $error("strobe order wrong");
  AST_FULL_SEQ: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    bus_start |=> ext_latch_strobe_o ##[1:8] bus_idle) else $error("bus cycle incomplete");
  AST_CAD_STOP: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_en && hit_cad) |=> !cad_run_q) else $error("cadence not stopped");
  AST_RING_TOGGLE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (ring_exp && !(wr_en && hit_ring)) |=> ring_out_q != $past(ring_out_q)) else $error("ring pin stuck");
  AST_CAD_IRQ: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cad_expire |=> dext_stat_q[periph_pkg::BIT_CAD_EXP]) else $error("cadence flag missing");
  AST_ADDR_PHASE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ext_latch_strobe_o |-> (port_pin_oe_o[7:0] == 8'hFF) && (port_pin_o[7:0] == ext_address_reg_q))
    else $error("address not on bus");
  AST_WR_PHASE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !ext_write_strobe_n_o |-> (port_pin_oe_o[7:0] == 8'hFF) && (port_pin_o[7:0] == ext_data_port_q))
    else $error("write data not on bus");
  AST_RD_RELEASE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !ext_read_strobe_n_o |-> port_pin_oe_o == 11'h000) else $error("bus driven during read");
  AST_STROBE_EXCL: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !(!ext_read_strobe_n_o && !ext_write_strobe_n_o)) else $error("both strobes active");
  AST_WR_LEN: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $fell(ext_write_strobe_n_o) |-> (!ext_write_strobe_n_o)[*4] ##1 ext_write_strobe_n_o)
    else $error("write strobe length wrong");
  AST_RD_LEN: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $fell(ext_read_strobe_n_o) |-> (!ext_read_strobe_n_o)[*4] ##1 ext_read_strobe_n_o)
    else $error("read strobe length wrong");
  AST_FLAG_CLEAR: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (clr_mstat && (mstat_set == 8'h00)) |=> main_stat_q == 8'h00) else $error("status not cleared");
  AST_SYNC_DELAY: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !$past(srst_i, 2) |-> lvl0 == $past(ext_irq_pin0_i, 2)) else $error("sync delay wrong");
  AST_BUSY_REFUSE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (reg_busy_o && reg_wr_i && hit_ext_address_reg) |=> ext_address_reg_q == $past(ext_address_reg_q)) else $error("write taken while busy");
endmodule : peripheral_control_unit

// ==== dv/periph_bus_model.sv ====
// Purpose: byte-wide peripheral on the far side of the port
// Assumes: latch strobe high one cycle with the address on pins 7:0
// Notes:   released lines show the bench idle pattern, except pins 7:0 show the addressed byte while the read strobe is low
module periph_bus_model (
  input  wire logic        ref_clk_i,
  input  wire logic [10:0] pin_drv_i,
  input  wire logic [10:0] pin_oe_i,
  input  wire logic        latch_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        bus_mode_i,
  input  wire logic [10:0] idle_i,
  output logic      [10:0] pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // peripheral storage
  // ----------------------------------------
  logic [7:0]  mem [256];
  logic [7:0]  addr_q;
  logic [10:0] far_lvl;
  always @(posedge ref_clk_i) begin
    if (latch_i) addr_q <= pin_drv_i[7:0];
    if (!wr_n_i) mem[addr_q] <= pin_drv_i[7:0];
  end
  // all 256 locations answer the read strobe
  assign far_lvl = (bus_mode_i && !rd_n_i) ? {idle_i[10:8], mem[addr_q]} : idle_i;
  assign pin_lvl_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & far_lvl);
endmodule : periph_bus_model

// ==== dv/testbench.sv ====
// Purpose: self-checking bench for the peripheral control unit
// Assumes: short timer steps, bench drives inputs on the falling edge
// Notes:   expected bytes kept in a bench memory and address queue
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, srst_i, reg_wr_i, reg_rd_i, busy, irq, ring, ring_q, lat, rdn, wrn, x0, x1;
  logic [7:0]  addr, wdata, rdata, got, a;
  logic [7:0]  exp_mem [256];
  logic [7:0]  aq [$];
  logic [10:0] pin_lvl, pin_o, pin_oe, idle;
  int          mismatches, samples_checked, seed, n, k, tog, lat_cnt;

  peripheral_control_unit #(.CAD_STEP_CYC(10), .RING_STEP_CYC(5)) u_peripheral_control_unit (
    .ref_clk_i           (ref_clk_i),
    .srst_i              (srst_i),
    .reg_addr_i          (addr),
    .reg_wdata_i         (wdata),
    .reg_wr_i            (reg_wr_i),
    .reg_rd_i            (reg_rd_i),
    .reg_rdata_o         (rdata),
    .reg_busy_o          (busy),
    .irq_o               (irq),
    .ext_irq_pin0_i      (x0),
    .ext_irq_pin1_i      (x1),
    .ring_timer_out_pin_o(ring),
    .port_pin_i          (pin_lvl),
    .port_pin_o          (pin_o),
    .port_pin_oe_o       (pin_oe),
    .ext_latch_strobe_o  (lat),
    .ext_read_strobe_n_o (rdn),
    .ext_write_strobe_n_o(wrn)
  );
  periph_bus_model u_periph_bus_model (
    .ref_clk_i (ref_clk_i),
    .pin_drv_i (pin_o),
    .pin_oe_i  (pin_oe),
    .latch_i   (lat),
    .rd_n_i    (rdn),
    .wr_n_i    (wrn),
    .bus_mode_i(1'h1),
    .idle_i    (idle),
    .pin_lvl_o (pin_lvl)
  );
  // ----------------------------------------
  // clock and monitors
  // ----------------------------------------
  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    ring_q <= ring;
    if (ring !== ring_q) tog++;
    if (lat === 1'h1) lat_cnt++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic idle_wait();
    int i;
    @(negedge ref_clk_i);
    for (i = 0; i < 50 && busy !== 1'h0; i++) @(negedge ref_clk_i);
    if (busy !== 1'h0) begin
      mismatches++;
      $display("Error at %0t: busy never dropped", $time);
      final_report();
    end
  endtask : idle_wait
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    idle_wait();
    addr = ad;
    wdata = d;
    reg_wr_i = 1'h1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    idle_wait();
    addr = ad;
    reg_rd_i = 1'h1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'h0;
    d = rdata;
  endtask : rd
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h52FA2E37;
    {srst_i, reg_wr_i, reg_rd_i, x0, x1} = 5'h10;
    addr = 8'h00;
    wdata = 8'h00;
    idle = 11'h5A5;
    repeat (20) @(negedge ref_clk_i);
    srst_i = 1'h0;
    rd(8'h18, got); chk(got, 8'hFF);
    rd(8'h20, got); chk(got, 8'hFF);
    rd(8'h04, got); chk(got, 8'h00);
    chk(irq, 1'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      if (k == 2) wr(8'h18, 8'hE7);
      x0 = ~x0;
      if (k[0]) x1 = ~x1;
      repeat (6) @(negedge ref_clk_i);
      chk(irq, k >= 2);
      rd(8'h60, got); chk(got[7:6], {x1, x0});
      rd(8'h14, got); chk(got[4:3], {k[0], 1'h1});
      chk(irq, 1'h0);
    end
    $display("test ext irq done");
    wr(8'h68, 8'hFC);
    for (k = 0; k < 4; k++) begin
      n = $random(seed);
      wr(8'hF4, n[7:0]);
      wr(8'hF8, {5'h00, n[10:8]});
      repeat (4) @(negedge ref_clk_i);
      chk(pin_oe, 11'h7FF);
      chk(pin_o, n[10:0]);
      rd(8'hF4, got); chk(got, n[7:0]);
    end
    wr(8'h68, 8'h00);
    idle = $random(seed);
    repeat (4) @(negedge ref_clk_i);
    chk(pin_oe, 11'h000);
    rd(8'hF4, got); chk(got, idle[7:0]);
    rd(8'hF8, got); chk(got[2:0], idle[10:8]);
    $display("test simple io done");
    wr(8'h68, 8'h02);
    for (k = 0; k < 6; k++) begin
      n = $random(seed);
      if (k < 2) n[7:0] = {8{k[0]}};
      exp_mem[n[7:0]] = n[15:8];
      aq.push_back(n[7:0]);
      lat_cnt = 0;
      wr(8'hF4, n[7:0]);
      wr(8'hF8, n[15:8]);
      rd(8'hF8, got);
      rd(8'hF8, got); chk(got, n[15:8]);
      idle_wait();
      chk(lat_cnt, 3);
    end
    while (aq.size() > 0) begin
      a = aq.pop_front();
      wr(8'hF4, a);
      rd(8'hF8, got);
      rd(8'hF8, got); chk(got, exp_mem[a]);
    end
    $display("test bus mode done");
    wr(8'h20, 8'hFD);
    wr(8'h18, 8'hE3);
    wr(8'h10, 8'h07);
    wr(8'h08, 8'h10);
    repeat (100) @(negedge ref_clk_i);
    chk(irq, 1'h1);
    rd(8'h1C, got); chk(got[1], 1'h1);
    repeat (100) @(negedge ref_clk_i);
    rd(8'h1C, got); chk(got[1], 1'h1);
    wr(8'h10, 8'h03);
    wr(8'h08, 8'h10);
    repeat (100) @(negedge ref_clk_i);
    rd(8'h1C, got); chk(got[1], 1'h1);
    repeat (100) @(negedge ref_clk_i);
    rd(8'h1C, got); chk(got[1], 1'h0);
    wr(8'h08, 8'h10);
    wr(8'h10, 8'h03);
    repeat (100) @(negedge ref_clk_i);
    rd(8'h1C, got); chk(got[1], 1'h0);
    $display("test cadence timer done");
    wr(8'h4C, 8'h83);
    tog = 0;
    repeat (150) @(negedge ref_clk_i);
    chk(tog >= 8 && tog <= 11, 1'h1);
    rd(8'h1C, got); chk(got[4], 1'h1);
    wr(8'h4C, 8'h00);
    @(negedge ref_clk_i);
    tog = 0;
    repeat (100) @(negedge ref_clk_i);
    chk(tog, 0);
    wr(8'h4C, 8'h03);
    @(negedge ref_clk_i);
    tog = 0;
    repeat (100) @(negedge ref_clk_i);
    chk(tog, 1);
    $display("test ring timer done");
    final_report();
  end
endmodule : testbench
